/* File: mfu_pkg.sv */
// Purpose: Shared constants for the multi-drop serial command link.
// Assumes: One system clock feeds both ends; a bit lasts sixteen clocks.
// Notes:   Frame check bytes are carried, not computed, at this level.
package mfu_pkg;
  localparam int         OSR             = 16;
  localparam logic [3:0] TICK_LAST       = 4'hf;
  localparam logic [3:0] TICK_MID        = 4'h7;
  localparam int         BREAK_BITS      = 12;
  localparam int         BREAK_CLKS      = BREAK_BITS * OSR;
  localparam int         HOST_BREAK_CLKS = BREAK_CLKS + OSR;
  localparam logic [2:0] DATA_LAST       = 3'h7;
  localparam logic [3:0] FRAME_LAST      = 4'h9;
  localparam logic [9:0] LINE_IDLE       = 10'h3ff;
  localparam int         FRAME_BIT       = 7;
  localparam int         KIND_MSB        = 6;
  localparam int         KIND_LSB        = 3;
  localparam int         FIELD_MSB       = 2;
  localparam logic [3:0] KIND_WR_LAST    = 4'h4;
  localparam logic [3:0] KIND_BCAST      = 4'h7;
  localparam logic [3:0] KIND_RD_FIRST   = 4'h8;
  localparam logic [3:0] KIND_RD_LAST    = 4'hc;
  localparam logic [2:0] BC_SYNC         = 3'h0;
  localparam logic [2:0] BC_FIELD_LAST   = 3'h5;
  localparam logic [3:0] RSP_RESERVED    = 4'h0;
  localparam logic [3:0] CHECK_BYTES     = 4'h2;
  localparam logic [4:0] REPLY_EXTRA     = 5'h3;

  // Length code to data byte count: 1, 2, 5, 10, 15.
  function automatic logic [3:0] mfu_len(input logic [2:0] code);
    case (code)
      3'h0:    mfu_len = 4'h1;
      3'h1:    mfu_len = 4'h2;
      3'h2:    mfu_len = 4'h5;
      3'h3:    mfu_len = 4'ha;
      3'h4:    mfu_len = 4'hf;
      default: mfu_len = 4'h0;
    endcase
  endfunction
endpackage

/* File: mfu_link_if.sv */
// Purpose: Serial line pair between the master and one slave end.
// Assumes: The slave transmit line has a pull-up; master drives its line always.
// Notes:   tx_line resolves the released transmit output to the idle high level.
`timescale 1ns/100ps
`default_nettype none
interface mfu_link_if;
  logic host_tx;
  logic dev_tx;
  logic dev_tx_oe;
  logic tx_line;

  // The pull-up holds the line high whenever the slave releases it.
  assign tx_line = dev_tx_oe ? dev_tx : 1'b1;

  modport dev  (input host_tx, output dev_tx, output dev_tx_oe);
  modport host (output host_tx, input tx_line);
endinterface
`default_nettype wire

/* File: mfu_dev.sv */
// Purpose: Slave end of the multi-drop command/response serial link.
// Assumes: Receive line is synchronous to clk; read data answers rd_addr at once.
// Notes:   Write strobes come per data byte; the check word is judged elsewhere.
// Overview of operation
// - Eight data bits, one stop, no parity.
// - Line idles high; start bit is low.
// - One bit lasts sixteen clock periods.
// - Receive sampled at sixteen times bit rate.
// - Master runs the same bit rate.
// - Low for 192 clocks resets receiver, protocol.
// - Master never breaks during a response.
// - Communications reset keeps registers and dimming.
// - Address is the three straps, bit2 first.
// - Transmit only in answer to master frames.
// - Transmit released unless sending a response.
// - Transactions start with addressed or broadcast command.
// - Single commands move 1,2,5,10,15 bytes.
// - Broadcast carries 0,1,2,5,10,15 bytes; zero means sync.
// - Reply only to own single-device read.
// - Write frame: init, address, data, two checks.
// - All registers writable and readable.
// - Init bit7 command, kind 6:3, field 2:0.
// - Reply: init with length code, data, two checks.
`timescale 1ns/100ps
`default_nettype none
module mfu_dev (
  input  wire logic        clk,
  input  wire logic        rst,
  mfu_link_if.dev          link,
  input  wire logic        addr_strap_bit0,
  input  wire logic        addr_strap_bit1,
  input  wire logic        addr_strap_bit2,
  output logic             wr_valid,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_bcast,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             rd_take,
  input  wire logic [15:0] reply_check,
  output logic [15:0]      frame_check,
  output logic             frame_done,
  output logic             sync_cmd,
  output logic             comm_reset
);
  localparam int BW = $clog2(mfu_pkg::BREAK_CLKS + 1);
  localparam logic [BW-1:0] BREAK_END = BW'(mfu_pkg::BREAK_CLKS - 1);

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } mfu_rx_t;

  typedef enum logic [4:0] {
    P_INIT  = 5'h01,
    P_ADDR  = 5'h02,
    P_DATA  = 5'h04,
    P_CHK   = 5'h08,
    P_REPLY = 5'h10
  } mfu_proto_t;

  mfu_rx_t       rx_st_q;
  mfu_proto_t    p_st_q;
  logic [BW-1:0] brk_cnt_q;
  logic          brk_q;
  logic [3:0]    rx_tick_q;
  logic [2:0]    rx_bit_q;
  logic [7:0]    rx_sh_q;
  logic          rd_q;
  logic          bc_q;
  logic          match_q;
  logic [3:0]    n_q;
  logic [2:0]    rcode_q;
  logic [3:0]    cnt_q;
  logic [7:0]    reg_addr_q;
  logic [7:0]    chk_q;
  logic [4:0]    sent_q;
  logic          tx_busy_q;
  logic [9:0]    tx_sh_q;
  logic [3:0]    tx_tick_q;
  logic [3:0]    tx_bit_q;
  logic          wr_valid_q;
  logic [7:0]    wr_addr_q;
  logic [7:0]    wr_data_q;
  logic          wr_bcast_q;
  logic [15:0]   frame_check_q;
  logic          frame_done_q;
  logic          sync_cmd_q;
  logic          comm_reset_q;

  wire rx = link.host_tx;

  // A long low marks a break; the receiver rearms only after the line returns high.
  wire brk_hit = !rx && !brk_q && (brk_cnt_q == BREAK_END);

  always_ff @(posedge clk) begin
    if (rst || rx || brk_q) begin
      brk_cnt_q <= '0;
    end else begin
      brk_cnt_q <= brk_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || rx) begin
      brk_q <= 1'b0;
    end else if (brk_hit) begin
      brk_q <= 1'b1;
    end
  end

  wire rx_mid  = (rx_tick_q == mfu_pkg::TICK_MID);
  wire rx_end  = (rx_tick_q == mfu_pkg::TICK_LAST);
  wire rx_adv  = ((rx_st_q == RX_START) && rx_mid) ||
                 (((rx_st_q == RX_DATA) || (rx_st_q == RX_STOP)) && rx_end);
  wire byte_v  = (rx_st_q == RX_STOP) && rx_end && rx;

  always_ff @(posedge clk) begin
    if (rst || brk_hit) begin
      rx_st_q   <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
    end else begin
      rx_tick_q <= ((rx_st_q == RX_IDLE) || rx_adv) ? 4'h0 : rx_tick_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rx && !brk_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_st_q  <= rx ? RX_IDLE : RX_DATA;
            rx_bit_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_sh_q  <= {rx, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == mfu_pkg::DATA_LAST) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Init byte decode.
  wire [3:0] kind     = rx_sh_q[mfu_pkg::KIND_MSB:mfu_pkg::KIND_LSB];
  wire [2:0] fld      = rx_sh_q[mfu_pkg::FIELD_MSB:0];
  wire       is_cmd   = rx_sh_q[mfu_pkg::FRAME_BIT];
  wire [2:0] my_addr  = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
  wire       k_wr     = (kind <= mfu_pkg::KIND_WR_LAST);
  wire       k_rd     = (kind >= mfu_pkg::KIND_RD_FIRST) && (kind <= mfu_pkg::KIND_RD_LAST);
  wire       k_bc     = (kind == mfu_pkg::KIND_BCAST) && (fld <= mfu_pkg::BC_FIELD_LAST);
  wire       init_ok  = is_cmd && (k_wr || k_rd || k_bc);
  wire [2:0] len_code = k_bc ? fld - 3'h1 : kind[2:0];
  wire       bc_sync  = k_bc && (fld == mfu_pkg::BC_SYNC);
  wire [3:0] n_init   = bc_sync ? 4'h0 : mfu_pkg::mfu_len(len_code);

  // Reply byte selection: init, data, check high, check low.
  wire [4:0] n_ext    = {1'b0, n_q};
  wire [4:0] total    = n_ext + mfu_pkg::REPLY_EXTRA;
  wire       sel_init = (sent_q == 5'h00);
  wire       sel_hi   = (sent_q == n_ext + 5'h01);
  wire       sel_lo   = (sent_q == n_ext + 5'h02);
  wire       sel_data = !sel_init && !sel_hi && !sel_lo;
  wire       in_reply = (p_st_q == P_REPLY);
  wire       tx_load  = in_reply && !tx_busy_q && (sent_q != total);
  wire       tx_fin   = in_reply && !tx_busy_q && (sent_q == total);
  wire [7:0] rsp_init = {1'b0, mfu_pkg::RSP_RESERVED, rcode_q};
  wire [7:0] tx_byte  = sel_init ? rsp_init :
                        sel_hi   ? reply_check[15:8] :
                        sel_lo   ? reply_check[7:0] : rd_data;

  always_ff @(posedge clk) begin
    wr_valid_q   <= 1'b0;
    frame_done_q <= 1'b0;
    sync_cmd_q   <= 1'b0;
    comm_reset_q <= brk_hit;
    if (rst || brk_hit) begin
      p_st_q        <= P_INIT;
      rd_q          <= 1'b0;
      bc_q          <= 1'b0;
      match_q       <= 1'b0;
      n_q           <= 4'h0;
      rcode_q       <= 3'h0;
      cnt_q         <= 4'h0;
      reg_addr_q    <= 8'h00;
      chk_q         <= 8'h00;
      sent_q        <= 5'h00;
      wr_addr_q     <= 8'h00;
      wr_data_q     <= 8'h00;
      wr_bcast_q    <= 1'b0;
      frame_check_q <= 16'h0000;
    end else begin
      case (p_st_q)
        P_INIT: begin
          if (byte_v && init_ok) begin
            rd_q    <= k_rd;
            bc_q    <= k_bc;
            match_q <= k_bc || (fld == my_addr);
            n_q     <= n_init;
            rcode_q <= len_code;
            if (bc_sync) begin
              p_st_q <= P_CHK;
              cnt_q  <= mfu_pkg::CHECK_BYTES;
            end else begin
              p_st_q <= P_ADDR;
            end
          end
        end
        P_ADDR: begin
          if (byte_v) begin
            reg_addr_q <= rx_sh_q;
            p_st_q     <= rd_q ? P_CHK : P_DATA;
            cnt_q      <= rd_q ? mfu_pkg::CHECK_BYTES : n_q;
          end
        end
        P_DATA: begin
          if (byte_v) begin
            wr_valid_q <= match_q;
            wr_data_q  <= rx_sh_q;
            wr_addr_q  <= reg_addr_q;
            wr_bcast_q <= bc_q;
            reg_addr_q <= reg_addr_q + 8'h01;
            cnt_q      <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              p_st_q <= P_CHK;
              cnt_q  <= mfu_pkg::CHECK_BYTES;
            end
          end
        end
        P_CHK: begin
          if (byte_v) begin
            chk_q <= rx_sh_q;
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              frame_done_q  <= match_q;
              frame_check_q <= {chk_q, rx_sh_q};
              sync_cmd_q    <= bc_q && (n_q == 4'h0);
              sent_q        <= 5'h00;
              p_st_q        <= (rd_q && match_q) ? P_REPLY : P_INIT;
            end
          end
        end
        P_REPLY: begin
          if (tx_load) begin
            sent_q <= sent_q + 5'h01;
            if (sel_data) begin
              reg_addr_q <= reg_addr_q + 8'h01;
            end
          end
          if (tx_fin) begin
            p_st_q <= P_INIT;
          end
        end
        default: p_st_q <= P_INIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || brk_hit) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= mfu_pkg::LINE_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q  <= 4'h0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_sh_q   <= {1'b1, tx_byte, 1'b0};
      tx_tick_q <= 4'h0;
      tx_bit_q  <= 4'h0;
    end else if (tx_busy_q) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_tick_q == mfu_pkg::TICK_LAST) begin
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == mfu_pkg::FRAME_LAST) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  assign link.dev_tx    = tx_sh_q[0];
  assign link.dev_tx_oe = in_reply;
  assign rd_take        = tx_load && sel_data;
  assign rd_addr        = reg_addr_q;
  assign wr_valid       = wr_valid_q;
  assign wr_addr        = wr_addr_q;
  assign wr_data        = wr_data_q;
  assign wr_bcast       = wr_bcast_q;
  assign frame_check    = frame_check_q;
  assign frame_done     = frame_done_q;
  assign sync_cmd       = sync_cmd_q;
  assign comm_reset     = comm_reset_q;
endmodule
`default_nettype wire

/* File: mfu_host.sv */
// Purpose: Master end of the serial link: byte sender, receiver and break maker.
// Assumes: Shares clk with the slaves, so both ends run the same bit rate.
// Notes:   The user side forms frames; this end moves bytes and breaks.
`timescale 1ns/100ps
`default_nettype none
module mfu_host (
  input  wire logic       clk,
  input  wire logic       rst,
  mfu_link_if.host        link,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_byte,
  input  wire logic       brk_req,
  output logic            brk_ready,
  output logic            brk_busy,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_err
);
  localparam int HBW = $clog2(mfu_pkg::HOST_BREAK_CLKS + 1);
  localparam logic [HBW-1:0] HBREAK_END = HBW'(mfu_pkg::HOST_BREAK_CLKS - 1);

  typedef enum logic [3:0] {
    HR_IDLE  = 4'h1,
    HR_START = 4'h2,
    HR_DATA  = 4'h4,
    HR_STOP  = 4'h8
  } mfu_hrx_t;

  mfu_hrx_t       rx_st_q;
  logic [3:0]     rx_tick_q;
  logic [2:0]     rx_bit_q;
  logic [7:0]     rx_sh_q;
  logic           rx_valid_q;
  logic           rx_err_q;
  logic           busy_q;
  logic           brk_q;
  logic [HBW-1:0] brk_cnt_q;
  logic [9:0]     sh_q;
  logic [3:0]     tick_q;
  logic [3:0]     bit_q;

  wire line    = link.tx_line;
  wire tx_go   = tx_valid && tx_ready;
  // A break is only allowed while the receiver is idle and the line is high.
  wire brk_go  = brk_req && brk_ready;
  wire brk_end = brk_q && (brk_cnt_q == HBREAK_END);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q    <= 1'b0;
      brk_q     <= 1'b0;
      brk_cnt_q <= '0;
      sh_q      <= mfu_pkg::LINE_IDLE;
      tick_q    <= 4'h0;
      bit_q     <= 4'h0;
    end else if (brk_go) begin
      brk_q     <= 1'b1;
      brk_cnt_q <= '0;
      sh_q      <= 10'h000;
    end else if (brk_q) begin
      brk_cnt_q <= brk_cnt_q + 1'b1;
      if (brk_end) begin
        brk_q <= 1'b0;
        sh_q  <= mfu_pkg::LINE_IDLE;
      end
    end else if (tx_go) begin
      busy_q <= 1'b1;
      sh_q   <= {1'b1, tx_byte, 1'b0};
      tick_q <= 4'h0;
      bit_q  <= 4'h0;
    end else if (busy_q) begin
      tick_q <= tick_q + 4'h1;
      if (tick_q == mfu_pkg::TICK_LAST) begin
        sh_q  <= {1'b1, sh_q[9:1]};
        bit_q <= bit_q + 4'h1;
        if (bit_q == mfu_pkg::FRAME_LAST) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

  wire rx_mid = (rx_tick_q == mfu_pkg::TICK_MID);
  wire rx_end = (rx_tick_q == mfu_pkg::TICK_LAST);
  wire rx_adv = ((rx_st_q == HR_START) && rx_mid) ||
                (((rx_st_q == HR_DATA) || (rx_st_q == HR_STOP)) && rx_end);

  always_ff @(posedge clk) begin
    rx_valid_q <= 1'b0;
    rx_err_q   <= 1'b0;
    if (rst) begin
      rx_st_q   <= HR_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
    end else begin
      rx_tick_q <= ((rx_st_q == HR_IDLE) || rx_adv) ? 4'h0 : rx_tick_q + 4'h1;
      case (rx_st_q)
        HR_IDLE: begin
          if (!line) begin
            rx_st_q <= HR_START;
          end
        end
        HR_START: begin
          if (rx_mid) begin
            rx_st_q  <= line ? HR_IDLE : HR_DATA;
            rx_bit_q <= 3'h0;
          end
        end
        HR_DATA: begin
          if (rx_end) begin
            rx_sh_q  <= {line, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == mfu_pkg::DATA_LAST) begin
              rx_st_q <= HR_STOP;
            end
          end
        end
        HR_STOP: begin
          if (rx_end) begin
            rx_valid_q <= line;
            rx_err_q   <= !line;
            rx_st_q    <= HR_IDLE;
          end
        end
        default: rx_st_q <= HR_IDLE;
      endcase
    end
  end

  assign link.host_tx = sh_q[0];
  assign tx_ready     = !busy_q && !brk_q;
  assign brk_ready    = !busy_q && !brk_q && (rx_st_q == HR_IDLE) && line;
  assign brk_busy     = brk_q;
  assign rx_valid     = rx_valid_q;
  assign rx_byte      = rx_sh_q;
  assign rx_err       = rx_err_q;
endmodule
`default_nettype wire

/* File: mfu_link_asserts.sv */
// Purpose: Watches the serial line pair between the master and a slave end.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes:   bit_q counts samples of a slave byte from its falling start edge.
`timescale 1ns/100ps
`default_nettype none
module mfu_link_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_tx,
  input wire logic dev_tx,
  input wire logic dev_tx_oe,
  input wire logic tx_line
);
  logic [7:0] bit_q;
  logic [7:0] bit_d;
  logic       line_q;
  logic [8:0] low_q;
  logic [8:0] low_d;
  wire        line_fell = line_q && !tx_line;

  assign bit_d = (bit_q == 8'h00) ? {7'h00, line_fell} :
                 (bit_q == 8'h9f) ? 8'h00 : bit_q + 8'h01;
  assign low_d = host_tx ? 9'h000 : ((low_q == 9'h1ff) ? low_q : low_q + 9'h001);

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_q  <= 8'h00;
      line_q <= 1'b1;
      low_q  <= 9'h000;
    end else begin
      bit_q  <= bit_d;
      line_q <= tx_line;
      low_q  <= low_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_state: assert property ($fell(rst) |-> host_tx && !dev_tx_oe)
    else $error("line not idle after reset");
  chk_released_high: assert property (!dev_tx_oe |-> dev_tx && tx_line)
    else $error("released line not high");
  chk_start_low: assert property (bit_q inside {[8'h01:8'h0f]} |-> !tx_line)
    else $error("start bit not low");
  chk_stop_high: assert property (bit_q inside {[8'h90:8'h9f]} |-> tx_line)
    else $error("stop bit not high");
  chk_dev_bit_len: assert property ($fell(tx_line) |-> !tx_line [*8] ##1 !tx_line [*8])
    else $error("slave bit shorter than sixteen clocks");
  chk_host_bit_len: assert property ($fell(host_tx) |-> !host_tx [*8] ##1 !host_tx [*8])
    else $error("master bit shorter than sixteen clocks");
  chk_oe_in_byte: assert property (bit_q != 8'h00 |-> dev_tx_oe)
    else $error("slave released line inside a byte");
  chk_oe_drops: assert property (dev_tx_oe && bit_q == 8'h00 |->
    ##[1:4] (!dev_tx_oe || bit_q != 8'h00))
    else $error("slave held line with no byte");
  chk_reply_after: assert property ($rose(dev_tx_oe) |-> host_tx && $past(host_tx, 6))
    else $error("slave drove line outside a reply");
  chk_no_break_reply: assert property (dev_tx_oe |-> low_q < 9'h0c0)
    else $error("break during a reply");

  cover property ($rose(dev_tx_oe));
  cover property (low_q == 9'h0c0);
  cover property (bit_q == 8'h9f && dev_tx_oe);
endmodule
`default_nettype wire

/* File: multidrop_uart_slave_frames_tb.sv */
// Purpose: Self-checking bench joining the master and slave ends of the link.
// Assumes: Register file modelled as read data = address xor a5.
// Notes:   The driver queues expected strobes, bytes and events.
`timescale 1ns/100ps
`default_nettype none
module multidrop_uart_slave_frames_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_byte = 8'h00;
  logic        brk_req = 1'b0;
  logic [2:0]  strap = 3'h0;
  logic [15:0] reply_check = 16'h0000;
  logic [7:0]  rd_addr, wr_addr, wr_data, rx_byte;
  logic [15:0] frame_check;
  logic        tx_ready, brk_ready, rx_valid, rx_err, wr_valid, wr_bcast;
  logic        frame_done, sync_cmd, comm_reset, rd_take, brk_busy;
  logic [16:0] q_wr[$];
  logic [7:0]  q_rx[$];
  logic [18:0] q_ev[$];
  int          fails = 0;
  int          n_tests = 0;
  int          n_take = 0;
  int          e_take = 0;
  int          n_brk = 0;
  int          lens[5] = '{1, 2, 5, 10, 15};
  wire  [7:0]  rd_data = rd_addr ^ 8'ha5;

  mfu_link_if link_i ();
  mfu_host u_mfu_host (.clk(clk), .rst(rst), .link(link_i), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .brk_req(brk_req), .brk_ready(brk_ready),
    .brk_busy(brk_busy), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err));
  mfu_dev u_mfu_dev (.clk(clk), .rst(rst), .link(link_i), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_bcast(wr_bcast), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_take(rd_take), .reply_check(reply_check), .frame_check(frame_check),
    .frame_done(frame_done), .sync_cmd(sync_cmd), .comm_reset(comm_reset));
  mfu_link_asserts u_link_asserts (.clk(clk), .rst(rst), .host_tx(link_i.host_tx),
    .dev_tx(link_i.dev_tx), .dev_tx_oe(link_i.dev_tx_oe), .tx_line(link_i.tx_line));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic note(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic cmp_wr(input logic [16:0] got);
    if (q_wr.size() == 0)
      note(1'b0, "unexpected write strobe");
    else
      note(q_wr.pop_front() === got, "write strobe mismatch");
  endtask

  task automatic cmp_rx(input logic [7:0] got);
    if (q_rx.size() == 0)
      note(1'b0, "unexpected reply byte");
    else
      note(q_rx.pop_front() === got, "reply byte mismatch");
  endtask

  task automatic cmp_ev(input logic [18:0] got);
    if (q_ev.size() == 0)
      note(1'b0, "unexpected frame event");
    else
      note(q_ev.pop_front() === got, "frame event mismatch");
  endtask

  always @(posedge clk) begin
    if (rst === 1'b0) begin
      if (wr_valid === 1'b1) cmp_wr({wr_bcast, wr_addr, wr_data});
      if (rx_valid === 1'b1) cmp_rx(rx_byte);
      if ((frame_done | sync_cmd | comm_reset) === 1'b1)
        cmp_ev({comm_reset, sync_cmd, frame_done, frame_done ? frame_check : 16'h0000});
      if (rx_err === 1'b1) note(1'b0, "stop bit low at master");
      if (rd_take === 1'b1) n_take++;
      if (brk_busy === 1'b1) n_brk++;
    end
  end

  // Waits for the master to be ready, then hands it one byte or one break.
  task automatic go(input bit is_brk, input logic [7:0] b);
    int i;
    i = 0;
    @(negedge clk);
    while ((is_brk ? brk_ready : tx_ready) !== 1'b1 && i < 400) begin
      @(negedge clk);
      i++;
    end
    if (i == 400) begin
      note(1'b0, "master never ready");
      test_done();
    end
    @(posedge clk);
    brk_req  <= is_brk;
    tx_valid <= !is_brk;
    tx_byte  <= b;
    @(posedge clk);
    brk_req  <= 1'b0;
    tx_valid <= 1'b0;
  endtask

  task automatic frame(input logic [7:0] init, input logic [7:0] ra, input int n,
                       input bit own);
    logic [7:0]  d;
    logic [15:0] chk;
    logic        sync;
    sync = init[6:3] == 4'h7 && n == 0;
    chk  = 16'($urandom);
    if (own) q_ev.push_back({1'b0, sync, 1'b1, chk});
    go(1'b0, init);
    if (!sync) go(1'b0, ra);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (own) q_wr.push_back({init[6:3] == 4'h7, ra + 8'(i), d});
      go(1'b0, d);
    end
    go(1'b0, chk[15:8]);
    go(1'b0, chk[7:0]);
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 8000 && q_wr.size() + q_rx.size() + q_ev.size() > 0; i++)
      @(posedge clk);
    if (i == 8000) begin
      note(1'b0, "results never came");
      test_done();
    end
    repeat (40) @(posedge clk);
  endtask

  initial begin
    logic [7:0] ra;
    logic [2:0] own;
    void'($urandom(32'hc85e));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      own = 3'($urandom);
      strap <= own;
      ra = 8'($urandom);
      frame({1'b1, 4'(k), own}, ra, lens[k], 1'b1);
      frame({1'b1, 4'(k), own ^ 3'h5}, ra, lens[k], 1'b0);
      drain();
    end
    frame(8'hb8, 8'h00, 0, 1'b1);
    for (int f = 1; f < 6; f++)
      frame({5'h17, 3'(f)}, 8'($urandom), lens[f - 1], 1'b1);
    drain();
    for (int k = 0; k < 5; k++) begin
      ra = 8'($urandom);
      reply_check <= 16'($urandom);
      frame({1'b1, 4'(k + 8), own ^ 3'h6}, ra, 0, 1'b0);
      frame({1'b1, 4'(k + 8), own}, ra, 0, 1'b1);
      q_rx.push_back({5'h00, 3'(k)});
      for (int i = 0; i < lens[k]; i++)
        q_rx.push_back((ra + 8'(i)) ^ 8'ha5);
      q_rx.push_back(reply_check[15:8]);
      q_rx.push_back(reply_check[7:0]);
      e_take += lens[k];
      drain();
      note(n_take == e_take, "read strobe count wrong");
    end
    go(1'b0, {1'b1, 4'h1, own});
    go(1'b0, 8'h10);
    q_ev.push_back({3'b100, 16'h0000});
    go(1'b1, 8'h00);
    repeat (260) @(posedge clk);
    note(n_brk == mfu_pkg::HOST_BREAK_CLKS, "break length wrong");
    drain();
    go(1'b0, {1'b1, 4'h5, own});
    go(1'b0, {1'b0, 4'h0, own});
    go(1'b0, {5'h17, 3'h6});
    frame({1'b1, 4'h0, own}, 8'h20, 1, 1'b1);
    drain();
    test_done();
  end
endmodule
`default_nettype wire
